// ### ocf_pkg.sv
/*
  Shared constants for the output control block: supply status register
  layout, fast-bus framing, stage numbering and the supply filter count.
  Assumes a 125 MHz system clock; all users refer to names as ocf_pkg::x.
*/
package ocf_pkg;

  // System clock rate, used to turn times into cycle counts
  localparam int unsigned SYS_CLK_MHZ    = 125;

  // Stage count and the stage that the fast bus never drives
  localparam int unsigned NUM_STAGES     = 16;
  localparam int unsigned STAGE8_IDX     = 7;

  // Fast-bus frame: 16 bits, bus clock may run from 0 up to 16 MHz
  localparam int unsigned FB_WIDTH       = 16;
  localparam int unsigned FB_MAX_MHZ     = 16;
  localparam int unsigned FB_TEST_BIT    = 8;
  localparam logic [15:0] FB_HOLD_RESET  = 16'hFFFF;

  // Supply status/control register, 8 bits, fields by position
  localparam int unsigned STAT_OV_BIT    = 0;
  localparam int unsigned STAT_UV_BIT    = 1;
  localparam int unsigned STAT_ABE_BIT   = 2;
  localparam int unsigned STAT_CFG_LSB   = 5;
  localparam logic [2:0]  STAT_CFG_RESET = 3'h7;

  // Release filter after the supply returns to its valid range
  localparam int unsigned FILTER_TIME_NS = 20000;
  localparam int unsigned FILTER_CYC     =
    (FILTER_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [11:0] FILTER_CNT     = 12'(FILTER_CYC);

endpackage

// ### ocf_sync.sv
/*
  Two-stage synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; multi-bit words must not pass here.
*/
`timescale 1ns/100ps

module ocf_sync
#(
  parameter int unsigned        WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ocf_sync_state_t;

  ocf_sync_state_t state_reg;
  ocf_sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb
  begin
    state_next        = state_reg;
    state_next.meta   = async_i;
    state_next.stable = state_reg.meta;
  end

  // Register the pair
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_reg <= {RESET_VAL, RESET_VAL};
    else
      state_reg <= state_next;
  end

  assign sync_o = state_reg.stable;

endmodule

// ### ocf_fb_rx.sv
/*
  Fast-bus shift register, clocked by the bus clock from the host.
  Assumes the host stops the bus clock before it raises the sync pin,
  so the word is quiet when the system domain picks it up.
*/
`timescale 1ns/100ps

module ocf_fb_rx
#(
  parameter int unsigned WIDTH = ocf_pkg::FB_WIDTH
)
(
  input  wire logic             fastbus_clock_pin_i,
  input  wire logic             reset_n_i,
  input  wire logic             fastbus_data_pin_i,
  output logic      [WIDTH-1:0] word_o
);

  typedef struct packed {
    logic [WIDTH-1:0] shift;
  } ocf_rx_state_t;

  ocf_rx_state_t state_reg;
  ocf_rx_state_t state_next;

  // First bit sent ends up in bit 0 after a full frame
  always_comb
  begin
    state_next       = state_reg;
    state_next.shift = {fastbus_data_pin_i, state_reg.shift[WIDTH-1:1]};
  end

  // Link-domain register; the bus clock may stand still between frames
  always_ff @(posedge fastbus_clock_pin_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign word_o = state_reg.shift;

  chk_shift_in_bit: assert property (
    @(posedge fastbus_clock_pin_i) disable iff (!reset_n_i)
    1'b1 |=> word_o[WIDTH-1] == $past(fastbus_data_pin_i)
  ) else $error("fast-bus data bit not shifted in");

endmodule

// ### ocf_ctrl.sv
/*
  Stage control selection and supply supervision: picks SPI, parallel pin
  or fast-bus control for each power stage, applies the external reset,
  drives the shutdown-enable pin from the supply comparators and holds the
  supply status/control register. Assumes the SPI block supplies decoded
  control bits, mux selections and register strobes, and that the analog
  comparators deliver levels asynchronous to the system clock.
*/
`timescale 1ns/100ps

module ocf_ctrl
#(
  parameter int unsigned NUM = ocf_pkg::NUM_STAGES
)
(
  input  wire logic           sys_clk_i,
  input  wire logic           reset_n_i,
  input  wire logic           fastbus_clock_pin_i,
  input  wire logic           fastbus_data_pin_i,
  input  wire logic           fastbus_sync_input_i,
  input  wire logic           ext_reset_n_i,
  input  wire logic           spi_ss_n_i,
  input  wire logic [NUM-1:0] parallel_in_i,
  input  wire logic [NUM-1:0] spi_ctrl_i,
  input  wire logic [NUM-1:0] stage_serial_sel_i,
  input  wire logic           bus_multiplex_bit_i,
  input  wire logic           cfg_wr_i,
  input  wire logic           stat_wr_i,
  input  wire logic [7:0]     stat_wdata_i,
  input  wire logic           vdd_under_i,
  input  wire logic           vdd_over_i,
  input  wire logic           vdd_below_3v5_i,
  input  wire logic           shutdown_enable_pin_i,
  output logic                shutdown_enable_pin_o,
  output logic                shutdown_enable_pin_oe_n_o,
  output logic [NUM-1:0]      stage_on_o,
  output logic [7:0]          stat_rdata_o,
  output logic                fb_test_bit_o,
  output logic [NUM-1:0]      input_levels_o,
  output logic                threshold_test_disable_bit_o,
  output logic                threshold_direction_bit_o
);

  localparam int unsigned S8 = ocf_pkg::STAGE8_IDX;

  // Synchroniser lane positions
  localparam int unsigned L_SYNC = 0;
  localparam int unsigned L_RST  = 1;
  localparam int unsigned L_ABE  = 2;
  localparam int unsigned L_SS   = 3;
  localparam int unsigned L_UV   = 4;
  localparam int unsigned L_OV   = 5;
  localparam int unsigned L_LOW  = 6;
  localparam int unsigned L_IN   = 7;
  localparam int unsigned LANES  = L_IN + NUM;

  // Shutdown pin and slave select idle high; the external reset lane starts low (asserted)
  localparam logic [LANES-1:0] LANE_RESET =
    LANES'((1 << L_SS) | (1 << L_ABE));

  typedef struct packed {
    logic [15:0]    hold;
    logic [NUM-1:0] spi_hold;
    logic [NUM-1:0] stage_on;
    logic [NUM-1:0] in_lvl;
    logic [2:0]     cfg;
    logic           ov_stored;
    logic [11:0]    filt;
    logic           abe_oe_n;
    logic           forced_spi;
    logic           sync_d;
    logic           ss_d;
    logic [7:0]     rdata;
    logic           test_bit;
  } ocf_ctrl_state_t;

  ocf_ctrl_state_t state_reg;
  ocf_ctrl_state_t state_next;

  logic [LANES-1:0] lane_sync;
  logic [15:0]      rx_word;
  logic [LANES-1:0] lane_raw;

  // Latched word to per-stage on levels; bit 0 means on
  function automatic logic [15:0] fb_map(input logic [15:0] w);
    logic [15:0] on;
    on     = '0;
    on[13] = ~w[0];
    on[6:0] = ~w[7:1];
    on[10] = ~w[9];
    on[9]  = ~w[10];
    on[8]  = ~w[11];
    on[11] = ~w[12];
    on[12] = ~w[13];
    on[15] = ~w[14];
    on[14] = ~w[15];
    return on;
  endfunction

  // Every pin except the fast-bus clock and data, and every comparator level, is brought in through two flops
  assign lane_raw = {parallel_in_i, vdd_below_3v5_i, vdd_over_i,
                     vdd_under_i, spi_ss_n_i, shutdown_enable_pin_i,
                     ext_reset_n_i, fastbus_sync_input_i};

  ocf_sync
  #(
    .WIDTH     (LANES),
    .RESET_VAL (LANE_RESET)
  )
  i_ocf_sync
  (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (lane_raw),
    .sync_o    (lane_sync)
  );

  // Link-domain receiver; word is read only after the sync edge
  ocf_fb_rx
  #(
    .WIDTH (ocf_pkg::FB_WIDTH)
  )
  i_ocf_fb_rx
  (
    .fastbus_clock_pin_i (fastbus_clock_pin_i),
    .reset_n_i           (reset_n_i),
    .fastbus_data_pin_i  (fastbus_data_pin_i),
    .word_o              (rx_word)
  );

  logic           ext_rst;
  logic           abe_low;
  logic           uv;
  logic           ov;
  logic           low3v5;
  logic [NUM-1:0] pins;
  logic           fault;
  logic           sync_rise;
  logic [15:0]    fb_on;

  assign ext_rst   = ~lane_sync[L_RST];
  assign abe_low   = ~lane_sync[L_ABE];
  assign uv        = lane_sync[L_UV];
  assign ov        = lane_sync[L_OV];
  assign low3v5    = lane_sync[L_LOW];
  assign pins      = lane_sync[L_IN +: NUM];
  assign fault     = uv | ov | state_reg.ov_stored;
  assign sync_rise = lane_sync[L_SYNC] & ~state_reg.sync_d;
  assign fb_on     = fb_map(state_reg.hold);

  // Next state: word capture, supply supervision, stage selection
  always_comb
  begin
    logic off_all;
    logic sel;
    off_all    = ext_rst | abe_low | uv;
    sel        = 1'b0;
    state_next = state_reg;
    state_next.sync_d = lane_sync[L_SYNC];
    state_next.ss_d   = lane_sync[L_SS];

    // Bus clock is stopped here, so the shift word is quiet when taken
    if (sync_rise)
      state_next.hold = rx_word;
    if (ext_rst)
      state_next.hold = ocf_pkg::FB_HOLD_RESET;

    // SPI bits take effect at the slave select rising edge
    if (lane_sync[L_SS] && !state_reg.ss_d)
      state_next.spi_hold = spi_ctrl_i;

    // SPI owns all stages but stage 8 after reset until the mux setup is rewritten
    if (ext_rst)
      state_next.forced_spi = 1'b1;
    else if (cfg_wr_i)
      state_next.forced_spi = 1'b0;

    // Only bits 7..5 are writable; status bits come from the monitor
    if (stat_wr_i)
      state_next.cfg = stat_wdata_i[7:ocf_pkg::STAT_CFG_LSB];

    // Clear written with bit 5 low wins over the set input
    if (ov && state_reg.cfg[0])
      state_next.ov_stored = 1'b1;
    else if (!state_reg.cfg[0])
      state_next.ov_stored = 1'b0;

    // Pin held low while out of range and for the filter time after
    if (fault)
      state_next.filt = ocf_pkg::FILTER_CNT;
    else if (state_reg.filt != '0)
      state_next.filt = state_reg.filt - 12'h001;
    state_next.abe_oe_n = ~(fault || state_next.filt != '0);

    // Per-stage source: parallel pin, SPI or fast bus
    for (int k = 0; k < NUM; k++)
    begin
      if (k == S8)
      begin
        if (stage_serial_sel_i[k])
          sel = state_reg.spi_hold[k] & ~off_all;
        else
          sel = pins[k] & ~low3v5 & ~ov & ~state_reg.ov_stored;
      end
      else if (state_reg.forced_spi)
        sel = state_reg.spi_hold[k] & ~off_all;
      else if (stage_serial_sel_i[k] && !bus_multiplex_bit_i)
        sel = fb_on[k] & ~off_all;
      else if (stage_serial_sel_i[k])
        sel = state_reg.spi_hold[k] & ~off_all;
      else
        sel = pins[k] & ~off_all;
      state_next.stage_on[k] = sel;
    end

    // Readback paths for the SPI side
    state_next.test_bit = state_reg.hold[ocf_pkg::FB_TEST_BIT];
    state_next.in_lvl   = pins;
    state_next.rdata    = '0;
    state_next.rdata[7:ocf_pkg::STAT_CFG_LSB] = state_reg.cfg;
    state_next.rdata[ocf_pkg::STAT_ABE_BIT]   = ~abe_low;
    state_next.rdata[ocf_pkg::STAT_UV_BIT]    = ~uv;
    state_next.rdata[ocf_pkg::STAT_OV_BIT]    =
      ~(ov | state_reg.ov_stored);
  end

  // Single state register; supply events touch no SPI-written register
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg            <= '0;
      state_reg.hold       <= ocf_pkg::FB_HOLD_RESET;
      state_reg.cfg        <= ocf_pkg::STAT_CFG_RESET;
      state_reg.abe_oe_n   <= 1'b1;
      state_reg.forced_spi <= 1'b1;
      state_reg.ss_d       <= 1'b1;
      state_reg.rdata      <= 8'hE7;
      // Test bit readback matches the all-off hold word from the start
      state_reg.test_bit   <= ocf_pkg::FB_HOLD_RESET[ocf_pkg::FB_TEST_BIT];
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Open-drain pin: only ever pulls low
  assign shutdown_enable_pin_o        = 1'b0;
  assign shutdown_enable_pin_oe_n_o   = state_reg.abe_oe_n;
  assign stage_on_o                   = state_reg.stage_on;
  assign stat_rdata_o                 = state_reg.rdata;
  assign fb_test_bit_o                = state_reg.test_bit;
  assign input_levels_o               = state_reg.in_lvl;
  assign threshold_test_disable_bit_o = state_reg.cfg[2];
  assign threshold_direction_bit_o    = state_reg.cfg[1];

  chk_reset_stages_off: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ext_rst |=> (stage_on_o & ~(NUM'(1) << S8)) == '0
  ) else $error("stage on during external reset");

  chk_sync_latch_word: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    sync_rise && !ext_rst |=> state_reg.hold == $past(rx_word)
  ) else $error("fast-bus word not latched at sync edge");

  chk_abe_drive_low: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (uv || ov) |=> !shutdown_enable_pin_oe_n_o
  ) else $error("shutdown pin not pulled low on supply fault");

  chk_abe_stages_off: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    abe_low && stage_serial_sel_i[S8] |=> stage_on_o == '0
  ) else $error("stage on while shutdown pin low");

  chk_uv_stages_off: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    uv && !abe_low |=> (stage_on_o & ~(NUM'(1) << S8)) == '0
  ) else $error("stage on during undervoltage");

  chk_filter_hold: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(fault) |-> (!shutdown_enable_pin_oe_n_o) [*8]
  ) else $error("shutdown pin released before filter time");

  chk_ov_latched: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    state_reg.ov_stored && state_reg.cfg[0] && !stat_wr_i
      |=> state_reg.ov_stored ##1 !stat_rdata_o[ocf_pkg::STAT_OV_BIT]
  ) else $error("stored overvoltage lost or not reported");

  chk_stage8_no_bus: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !stage_serial_sel_i[S8] && !low3v5 && !ov && !state_reg.ov_stored
      |=> stage_on_o[S8] == $past(pins[S8])
  ) else $error("parallel stage 8 not following its pin");

  chk_stage8_spi_only: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    stage_serial_sel_i[S8] && !ext_rst && !abe_low && !uv
      |=> stage_on_o[S8] == $past(state_reg.spi_hold[S8])
  ) else $error("serial stage 8 not following its SPI bit");

  chk_ext_reset_hold: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ext_rst |=> state_reg.hold == ocf_pkg::FB_HOLD_RESET
  ) else $error("hold word not all-off during external reset");

  chk_test_bit_read: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    sync_rise && !ext_rst ##1 !ext_rst
      |=> fb_test_bit_o == $past(rx_word[ocf_pkg::FB_TEST_BIT], 2)
  ) else $error("test bit readback does not match latched word");

endmodule

// ### ocf_host_model.sv
/*
  Host model for the fast bus: clock, data and sync pins of one frame.
  Assumes the bench calls send_frame from a single process at a time.
*/
`timescale 1ns/100ps

module ocf_host_model
#(
  parameter int unsigned HALF_NS = 24
)
(
  output logic fastbus_clock_pin_o,
  output logic fastbus_data_pin_o,
  output logic fastbus_sync_input_o
);
  // Bus idle: clock stands low between frames
  initial
  begin
    fastbus_clock_pin_o  = 1'b0;
    fastbus_data_pin_o   = 1'b0;
    fastbus_sync_input_o = 1'b0;
  end

  // First bit out is D0; 48 ns clock runs above the 16 MHz bus limit
  task automatic send_frame(input logic [15:0] word);
    for (int i = 0; i < 16; i++)
    begin
      fastbus_data_pin_o = word[i];
      #(HALF_NS);
      fastbus_clock_pin_o = 1'b1;
      #(HALF_NS);
      fastbus_clock_pin_o = 1'b0;
    end
    #(HALF_NS);
    fastbus_sync_input_o = 1'b1;
    // Clock and data frozen while the word is picked up
    #100;
    fastbus_sync_input_o = 1'b0;
    fastbus_data_pin_o = ~fastbus_data_pin_o;
  endtask
endmodule

// ### test_output_control_fastbus_supply_guard.sv
/*
  Bench for ocf_ctrl: SPI, parallel and fast-bus control, supply monitor.
  Assumes ocf_pkg constants and the host model for the fast-bus pins.
*/
`timescale 1ns/100ps

module test_output_control_fastbus_supply_guard;
  logic        sys_clk_i;
  logic        reset_n_i;
  logic        fb_clk;
  logic        fb_dat;
  logic        fb_syn;
  logic        ext_rst_n;
  logic        ss_n;
  logic [15:0] par_in;
  logic [15:0] spi_ctrl;
  logic [15:0] sel;
  logic        bus_multiplex_bit;
  logic        cfg_wr;
  logic        st_wr;
  logic [7:0]  st_wd;
  logic        uv;
  logic        ov;
  logic        low3;
  logic        sd_ext;
  logic        sd_short;
  logic        sd_wire;
  logic        sd_out;
  logic        sd_oe_n;
  logic [15:0] st_on;
  logic [7:0]  st_rd;
  logic        tbit;
  logic [15:0] levels;
  logic        tdis;
  logic        tdir;
  int          n_fail;
  int          checks_done;
  int          n;
  logic [15:0] words [4] = '{16'h1234, 16'hFEDC, 16'h0100, 16'hFFFE};

  // Open-drain wire: pulled high unless the bench pulls low, or the device pulls low while sd_short is off
  assign sd_wire = (sd_oe_n | sd_short) ? sd_ext : sd_out;

  ocf_host_model i_ocf_host_model (
    .fastbus_clock_pin_o  (fb_clk),
    .fastbus_data_pin_o   (fb_dat),
    .fastbus_sync_input_o (fb_syn)
  );

  ocf_ctrl i_ocf_ctrl (
    .sys_clk_i                    (sys_clk_i),
    .reset_n_i                    (reset_n_i),
    .fastbus_clock_pin_i          (fb_clk),
    .fastbus_data_pin_i           (fb_dat),
    .fastbus_sync_input_i         (fb_syn),
    .ext_reset_n_i                (ext_rst_n),
    .spi_ss_n_i                   (ss_n),
    .parallel_in_i                (par_in),
    .spi_ctrl_i                   (spi_ctrl),
    .stage_serial_sel_i           (sel),
    .bus_multiplex_bit_i          (bus_multiplex_bit),
    .cfg_wr_i                     (cfg_wr),
    .stat_wr_i                    (st_wr),
    .stat_wdata_i                 (st_wd),
    .vdd_under_i                  (uv),
    .vdd_over_i                   (ov),
    .vdd_below_3v5_i              (low3),
    .shutdown_enable_pin_i        (sd_wire),
    .shutdown_enable_pin_o        (sd_out),
    .shutdown_enable_pin_oe_n_o   (sd_oe_n),
    .stage_on_o                   (st_on),
    .stat_rdata_o                 (st_rd),
    .fb_test_bit_o                (tbit),
    .input_levels_o               (levels),
    .threshold_test_disable_bit_o (tdis),
    .threshold_direction_bit_o    (tdir)
  );

  // System clock, 8 ns
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs set after cyc change 1 ns after a rising edge
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic stat_write(input logic [7:0] d);
    st_wr = 1'b1;
    st_wd = d;
    cyc(1);
    st_wr = 1'b0;
    cyc(3);
  endtask

  task automatic spi_apply(input logic [15:0] v);
    spi_ctrl = v;
    ss_n = 1'b0;
    cyc(2);
    ss_n = 1'b1;
    cyc(8);
  endtask

  // Bounded wait for the shutdown pin release, counts cycles
  task automatic wait_release();
    n = 0;
    while (sd_oe_n !== 1'b1 && n < 4000)
    begin
      cyc(1);
      n++;
    end
  endtask

  // Fast-bus word to stage bits, 0 means on, stage 8 untouched
  function automatic logic [15:0] fb_map(input logic [15:0] w);
    logic [15:0] d;
    d = ~w;
    return {d[14], d[15], d[0], d[13], d[12], d[9], d[10], d[11],
            1'b0, d[7:1]};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog well beyond the ~11k cycles the tests need
  initial
  begin
    #500000;
    n_fail++;
    final_report();
  end

  initial
  begin
    {ss_n, ext_rst_n, sd_ext} = 3'h7;
    reset_n_i = 1'b0;
    {cfg_wr, st_wr, uv, ov, low3, bus_multiplex_bit, sd_short} = 7'h00;
    {par_in, spi_ctrl, st_wd} = 40'h0;
    sel = 16'hFFFF;
    n_fail = 0;
    checks_done = 0;
    cyc(4);
    check(st_on, 16'h0000);
    check(16'(st_rd), 16'h00E7);
    check(16'(tbit), 16'h0001);
    reset_n_i = 1'b1;
    cyc(3);
    // SPI owns the stages until the mux is written
    spi_apply(16'hA5C3);
    check(st_on, 16'hA5C3);
    sel = 16'hFF7F;
    par_in = 16'h0080;
    ext_rst_n = 1'b0;
    cyc(5);
    check(st_on, 16'h0080);
    ext_rst_n = 1'b1;
    sel = 16'hFFFF;
    cyc(3);
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    spi_apply(16'h0080);
    check(st_on, 16'h0080);
    // Frames back to back, each word checked on the stages
    foreach (words[i])
    begin
      i_ocf_host_model.send_frame(words[i]);
      cyc(6);
      check(st_on, fb_map(words[i]) | 16'h0080);
      check(16'(tbit), 16'(words[i][8]));
    end
    par_in = 16'h9F1F;
    cyc(4);
    check(levels, 16'h9F1F);
    bus_multiplex_bit = 1'b1;
    cyc(4);
    check(st_on, 16'h0080);
    sel = 16'h0000;
    par_in = 16'h00FF;
    cyc(5);
    check(st_on, 16'h00FF);
    // Undervoltage with the pin shorted high
    uv = 1'b1;
    sd_short = 1'b1;
    cyc(5);
    check(16'(sd_oe_n), 16'h0000);
    check(16'(sd_out), 16'h0000);
    check(st_on, 16'h0080);
    check(16'(st_rd[1]), 16'h0000);
    low3 = 1'b1;
    cyc(5);
    check(st_on, 16'h0000);
    {uv, low3, sd_short} = 3'h0;
    wait_release();
    check(16'(n >= 2500 && n <= 2512), 16'h0001);
    cyc(3);
    check(st_on, 16'h00FF);
    // Latched overvoltage: cleared during OV, it latches again on re-enable
    ov = 1'b1;
    cyc(5);
    check(16'(sd_oe_n), 16'h0000);
    check(16'(st_rd[0]), 16'h0000);
    stat_write(8'hC0);
    stat_write(8'hE0);
    ov = 1'b0;
    cyc(3000);
    check(16'(sd_oe_n), 16'h0000);
    stat_write(8'hC0);
    stat_write(8'hE0);
    wait_release();
    check(16'(st_rd[0]), 16'h0001);
    // Unlatched release after the filter
    stat_write(8'hC0);
    ov = 1'b1;
    cyc(5);
    ov = 1'b0;
    wait_release();
    check(16'(n >= 2500 && n <= 2512), 16'h0001);
    stat_write(8'hE0);
    // External low on the shutdown pin
    sd_ext = 1'b0;
    cyc(5);
    check(st_on, 16'h0080);
    check(16'(st_rd[2]), 16'h0000);
    sd_ext = 1'b1;
    cyc(5);
    check(st_on, 16'h00FF);
    stat_write(8'h40);
    check(16'({tdis, tdir}), 16'h0001);
    stat_write(8'h1F);
    check(16'(st_rd), 16'h0007);
    stat_write(8'hE0);
    check(16'(st_rd), 16'h00E7);
    final_report();
  end
endmodule
